// ==== include/sdsr_pkg.sv ====
// Constants, carriers and state codes of the serial data and status register block.
// Assumes a 32-bit Avalon-MM master that uses byte addresses.
package sdsr_pkg;

	// ---------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ---------------------------------------------------------------
	localparam logic [11:0] SDSR_IDX_STATUS_A   = 12'h0c0;
	localparam logic [11:0] SDSR_IDX_CONTROL_B  = 12'h0c1;
	localparam logic [11:0] SDSR_IDX_CONTROL_C  = 12'h0c2;
	localparam logic [11:0] SDSR_IDX_BAUD       = 12'h0c4;
	localparam logic [11:0] SDSR_IDX_DATA       = 12'h0c6;
	localparam logic [11:0] SDSR_ADDR_STATUS_A  = SDSR_IDX_STATUS_A << 2;
	localparam logic [11:0] SDSR_ADDR_CONTROL_B = SDSR_IDX_CONTROL_B << 2;
	localparam logic [11:0] SDSR_ADDR_CONTROL_C = SDSR_IDX_CONTROL_C << 2;
	localparam logic [11:0] SDSR_ADDR_BAUD      = SDSR_IDX_BAUD << 2;
	localparam logic [11:0] SDSR_ADDR_DATA      = SDSR_IDX_DATA << 2;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] SDSR_STATUS_A_RST  = 8'h20;
	localparam logic [7:0] SDSR_CONTROL_B_RST = 8'h00;
	localparam logic [7:0] SDSR_CONTROL_C_RST = 8'h06;
	localparam logic [7:0] SDSR_DATA_RST      = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int SDSR_SA_RXC   = 7;
	localparam int SDSR_SA_TXC   = 6;
	localparam int SDSR_SA_UDRE  = 5;
	localparam int SDSR_SA_U2X   = 1;
	localparam int SDSR_SA_MPCM  = 0;
	localparam int SDSR_CB_RECEIVE_IRQ_ENABLE = 7;
	localparam int SDSR_CB_TRANSMIT_IRQ_ENABLE = 6;
	localparam int SDSR_CB_EMPTY_IRQ_ENABLE = 5;
	localparam int SDSR_CB_RXEN  = 4;
	localparam int SDSR_CB_TXEN  = 3;
	localparam int SDSR_CB_SIZE2 = 2;
	localparam int SDSR_CB_TXB8  = 0;
	localparam int SDSR_CC_MODE  = 6;
	localparam int SDSR_CC_PAREN = 5;
	localparam int SDSR_CC_PODD  = 4;
	localparam int SDSR_CC_STOP2 = 3;
	localparam int SDSR_CC_SIZE1 = 2;
	localparam int SDSR_CC_SIZE0 = 1;

	localparam logic [1:0] SDSR_MODE_ASYNC = 2'b00;
	localparam logic [1:0] SDSR_MODE_SPI   = 2'b11;

	// ---------------------------------------------------------------
	// Timing: divider ticks per bit
	// ---------------------------------------------------------------
	localparam int         SDSR_TICKS_NORMAL    = 16;
	localparam int         SDSR_TICKS_DOUBLE    = 8;
	localparam logic [3:0] SDSR_TICKS_NORMAL_M1 = 4'(SDSR_TICKS_NORMAL - 1);
	localparam logic [3:0] SDSR_TICKS_DOUBLE_M1 = 4'(SDSR_TICKS_DOUBLE - 1);

	// ---------------------------------------------------------------
	// Carriers and states
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [31:0] writedata;
	} sdsr_bus_req_s;

	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       dor;
		logic       pe;
	} sdsr_rx_entry_s;

	typedef enum logic [2:0] {
		SDSR_IDLE  = 3'b000,
		SDSR_START = 3'b001,
		SDSR_DATA  = 3'b010,
		SDSR_PAR   = 3'b011,
		SDSR_STOP  = 3'b100
	} sdsr_line_state_e;

endpackage : sdsr_pkg

// ==== core/sdsr_core.sv ====
// Serial port data buffer, status register, baud divider and line shifters.
// Assumes an Avalon-MM master on sys_clk_in and an asynchronous rxd line.
`timescale 1ns/1ps

module sdsr_core #(
	parameter int DIV_W = 12
) (
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  resetn_in,
	// Avalon-MM slave
	input  wire sdsr_pkg::sdsr_bus_req_s bus_req_in,
	output logic [31:0]                bus_readdata_out,
	output logic                       bus_waitrequest_out,
	// Serial line
	input  wire logic                  rxd_in,
	output logic                       txd_out,
	output logic                       tx_drive_out,
	// Interrupt requests
	input  wire logic                  tx_irq_ack_in,
	output logic                       rx_irq_out,
	output logic                       tx_irq_out,
	output logic                       empty_irq_out
);
	import sdsr_pkg::*;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0]       ctrl_b_ff, ctrl_c_ff;
	logic [DIV_W-1:0] baud_ff;
	logic             u2x_ff, mpcm_ff, txc_ff, udre_ff, wait_ff, pop_ok_ff;
	logic [31:0]      rdata_ff;
	logic [8:0]       tx_buf_ff, tx_shift_ff, rx_data_ff;
	logic             sync1_ff, sync2_ff, sync3_ff, rx_line_ff;
	sdsr_line_state_e rx_state_ff, tx_state_ff;
	logic [DIV_W-1:0] rx_pre_ff, tx_pre_ff;
	logic [3:0]       rx_tcnt_ff, tx_tcnt_ff, rx_idx_ff, tx_idx_ff;
	logic             rx_pe_ff, rx_stop_ff, rx_done_ff, tx_par_ff, tx_stop2_ff;
	logic             txd_ff, drive_ff, rx_irq_ff, tx_irq_ff, empty_irq_ff;
	sdsr_rx_entry_s   fifo_ff [2];
	sdsr_rx_entry_s   hold_ff;
	logic             hold_v_ff, head_ff;
	logic [1:0]       fifo_cnt_ff;
	logic [DIV_W+4:0] tx_clks_ff;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	wire req       = bus_req_in.read | bus_req_in.write;
	wire acc       = req & ~wait_ff;
	wire hit_stat  = bus_req_in.address == SDSR_ADDR_STATUS_A;
	wire hit_cb    = bus_req_in.address == SDSR_ADDR_CONTROL_B;
	wire hit_cc    = bus_req_in.address == SDSR_ADDR_CONTROL_C;
	wire hit_baud  = bus_req_in.address == SDSR_ADDR_BAUD;
	wire hit_data  = bus_req_in.address == SDSR_ADDR_DATA;
	wire wr_acc    = acc & bus_req_in.write;
	wire [31:0] wd = bus_req_in.writedata;

	// ---------------------------------------------------------------
	// Configuration decode
	// ---------------------------------------------------------------
	wire [1:0] mode      = ctrl_c_ff[SDSR_CC_MODE +: 2];
	wire       spi_mode  = mode == SDSR_MODE_SPI;
	wire       fast      = u2x_ff & (mode == SDSR_MODE_ASYNC);
	wire [3:0] tpb_m1    = fast ? SDSR_TICKS_DOUBLE_M1 : SDSR_TICKS_NORMAL_M1;
	wire [3:0] half_m1   = tpb_m1 >> 1;
	wire [2:0] size_code = {ctrl_b_ff[SDSR_CB_SIZE2], ctrl_c_ff[SDSR_CC_SIZE1],
	                        ctrl_c_ff[SDSR_CC_SIZE0]};
	wire       nine      = size_code == 3'b111;
	wire [3:0] nbits_m1  = nine ? 4'd8 : ({2'b00, size_code[1:0]} + 4'd4);
	wire [8:0] mask      = 9'h1ff >> (4'd8 - nbits_m1);
	wire       rxen      = ctrl_b_ff[SDSR_CB_RXEN];
	wire       txen      = ctrl_b_ff[SDSR_CB_TXEN];
	wire       par_en    = ctrl_c_ff[SDSR_CC_PAREN];
	wire       par_odd   = ctrl_c_ff[SDSR_CC_PODD];

	// ---------------------------------------------------------------
	// Receive FIFO view
	// ---------------------------------------------------------------
	sdsr_rx_entry_s head, new_ent, mv_ent;
	assign head    = fifo_ff[head_ff];
	wire rxc       = fifo_cnt_ff != 2'd0;
	wire fe_rd     = rxc & head.fe & ~spi_mode;
	wire dor_rd    = rxc & head.dor & ~spi_mode;
	wire pe_rd     = rxc & head.pe & ~spi_mode;
	wire [7:0] rd_status = {rxc, txc_ff, udre_ff, fe_rd, dor_rd, pe_rd, u2x_ff, mpcm_ff};
	wire [7:0] rd_cb     = {ctrl_b_ff[7:2], rxc & head.data[8], ctrl_b_ff[0]};
	wire [7:0] rd_data   = rxc ? (head.data[7:0] & mask[7:0]) : SDSR_DATA_RST;
	wire [31:0] rd_word  = hit_stat ? {24'h0, rd_status} :
	                       hit_cb   ? {24'h0, rd_cb} :
	                       hit_cc   ? {24'h0, ctrl_c_ff} :
	                       hit_baud ? {{(32-DIV_W){1'b0}}, baud_ff} :
	                       hit_data ? {24'h0, rd_data} : 32'h0;

	// Pop uses occupancy seen when read data was captured, so a late push is not lost
	wire pop      = acc & bus_req_in.read & hit_data & pop_ok_ff & rxc;
	wire move     = hold_v_ff & ((fifo_cnt_ff != 2'd2) | pop);
	wire discard  = mpcm_ff & ~(nine & rx_data_ff[8]);
	wire keep     = rx_done_ff & ~discard;
	wire wr_idx   = head_ff + fifo_cnt_ff[0];
	assign new_ent = '{data: rx_data_ff & mask, fe: ~rx_stop_ff, dor: 1'b0, pe: rx_pe_ff};

	// ---------------------------------------------------------------
	// Line timing
	// ---------------------------------------------------------------
	wire rx_tick    = rx_pre_ff == baud_ff;
	wire rx_bit_end = rx_tick &
	                  (rx_tcnt_ff == ((rx_state_ff == SDSR_START) ? half_m1 : tpb_m1));
	wire start_det  = (rx_state_ff == SDSR_IDLE) & ~rx_line_ff;
	wire ovr_det    = start_det & hold_v_ff & (fifo_cnt_ff == 2'd2);
	assign mv_ent   = '{data: hold_ff.data, fe: hold_ff.fe, dor: hold_ff.dor | ovr_det,
	                    pe: hold_ff.pe};
	wire tx_tick    = tx_pre_ff == baud_ff;
	wire tx_bit_end = tx_tick & (tx_tcnt_ff == tpb_m1);
	wire tx_load    = (tx_state_ff == SDSR_IDLE) & txen & ~udre_ff;
	wire tx_done    = (tx_state_ff == SDSR_STOP) & tx_bit_end &
	                  (~ctrl_c_ff[SDSR_CC_STOP2] | tx_stop2_ff);
	wire wr_data_ok = wr_acc & hit_data & udre_ff;
	wire txc_set    = tx_done & udre_ff;
	wire txc_clr    = tx_irq_ack_in | (wr_acc & hit_stat & wd[SDSR_SA_TXC]);

	// ---------------------------------------------------------------
	// Bus slave and software registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			wait_ff   <= 1'b1;
			rdata_ff  <= 32'h0;
			pop_ok_ff <= 1'b0;
			ctrl_b_ff <= SDSR_CONTROL_B_RST;
			ctrl_c_ff <= SDSR_CONTROL_C_RST;
			baud_ff   <= '0;
			u2x_ff    <= SDSR_STATUS_A_RST[SDSR_SA_U2X];
			mpcm_ff   <= SDSR_STATUS_A_RST[SDSR_SA_MPCM];
			txc_ff    <= SDSR_STATUS_A_RST[SDSR_SA_TXC];
			udre_ff   <= SDSR_STATUS_A_RST[SDSR_SA_UDRE];
			tx_buf_ff <= '0;
		end else begin
			// One wait cycle, then a single accept cycle
			wait_ff <= ~(req & wait_ff);
			if (bus_req_in.read && wait_ff) begin
				rdata_ff  <= rd_word;
				pop_ok_ff <= rxc;
			end
			if (wr_acc && hit_cb) ctrl_b_ff <= wd[7:0];
			if (wr_acc && hit_cc) ctrl_c_ff <= wd[7:0];
			if (wr_acc && hit_baud) baud_ff <= wd[DIV_W-1:0];
			if (wr_acc && hit_stat) begin
				u2x_ff  <= wd[SDSR_SA_U2X];
				mpcm_ff <= wd[SDSR_SA_MPCM];
			end
			txc_ff <= txc_set | (txc_ff & ~txc_clr);
			if (tx_load) udre_ff <= 1'b1;
			else if (wr_data_ok) udre_ff <= 1'b0;
			if (wr_data_ok) tx_buf_ff <= {ctrl_b_ff[SDSR_CB_TXB8], wd[7:0]};
		end
	end

	// ---------------------------------------------------------------
	// Receive line synchroniser and shifter
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			sync1_ff   <= 1'b1;
			sync2_ff   <= 1'b1;
			sync3_ff   <= 1'b1;
			rx_line_ff <= 1'b1;
		end else begin
			sync1_ff <= rxd_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			if (sync2_ff == sync3_ff) rx_line_ff <= sync3_ff;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || !rxen) begin
			rx_state_ff <= SDSR_IDLE;
			rx_pre_ff   <= '0;
			rx_tcnt_ff  <= 4'd0;
			rx_idx_ff   <= 4'd0;
			rx_data_ff  <= '0;
			rx_pe_ff    <= 1'b0;
			rx_stop_ff  <= 1'b1;
			rx_done_ff  <= 1'b0;
		end else begin
			rx_done_ff <= 1'b0;
			rx_pre_ff  <= (rx_state_ff == SDSR_IDLE || rx_tick) ? '0 : rx_pre_ff + 1'b1;
			if (rx_state_ff == SDSR_IDLE || rx_bit_end) rx_tcnt_ff <= 4'd0;
			else if (rx_tick) rx_tcnt_ff <= rx_tcnt_ff + 4'd1;
			case (rx_state_ff)
				SDSR_IDLE: begin
					if (start_det) begin
						rx_state_ff <= SDSR_START;
						rx_data_ff  <= '0;
						rx_idx_ff   <= 4'd0;
						rx_pe_ff    <= 1'b0;
					end
				end
				SDSR_START: begin
					// A start bit gone by mid-bit is noise
					if (rx_bit_end) rx_state_ff <= rx_line_ff ? SDSR_IDLE : SDSR_DATA;
				end
				SDSR_DATA: begin
					if (rx_bit_end) begin
						rx_data_ff[rx_idx_ff] <= rx_line_ff;
						rx_idx_ff             <= rx_idx_ff + 4'd1;
						if (rx_idx_ff == nbits_m1) rx_state_ff <= par_en ? SDSR_PAR : SDSR_STOP;
					end
				end
				SDSR_PAR: begin
					if (rx_bit_end) begin
						rx_pe_ff    <= rx_line_ff ^ (^rx_data_ff) ^ par_odd;
						rx_state_ff <= SDSR_STOP;
					end
				end
				SDSR_STOP: begin
					if (rx_bit_end) begin
						rx_stop_ff  <= rx_line_ff;
						rx_done_ff  <= 1'b1;
						rx_state_ff <= SDSR_IDLE;
					end
				end
				default: rx_state_ff <= SDSR_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Receive FIFO with one waiting character
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in || !rxen) begin
			fifo_cnt_ff <= 2'd0;
			head_ff     <= 1'b0;
			hold_v_ff   <= 1'b0;
			hold_ff     <= '0;
			fifo_ff[0]  <= '0;
			fifo_ff[1]  <= '0;
		end else begin
			fifo_cnt_ff <= fifo_cnt_ff - {1'b0, pop} + {1'b0, move};
			if (pop) head_ff <= ~head_ff;
			if (move) fifo_ff[wr_idx] <= mv_ent;
			if (move || (keep && !hold_v_ff)) begin
				hold_v_ff <= keep;
				hold_ff   <= new_ent;
			end else if (ovr_det) begin
				hold_ff.dor <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Transmit shifter
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			tx_state_ff <= SDSR_IDLE;
			tx_pre_ff   <= '0;
			tx_tcnt_ff  <= 4'd0;
			tx_idx_ff   <= 4'd0;
			tx_shift_ff <= '0;
			tx_par_ff   <= 1'b0;
			tx_stop2_ff <= 1'b0;
			tx_clks_ff  <= '0;
		end else begin
			tx_pre_ff  <= (tx_state_ff == SDSR_IDLE || tx_tick) ? '0 : tx_pre_ff + 1'b1;
			tx_clks_ff <= (tx_load || tx_bit_end) ? '0 : tx_clks_ff + 1'b1;
			if (tx_state_ff == SDSR_IDLE || tx_bit_end) tx_tcnt_ff <= 4'd0;
			else if (tx_tick) tx_tcnt_ff <= tx_tcnt_ff + 4'd1;
			case (tx_state_ff)
				SDSR_IDLE: begin
					if (tx_load) begin
						tx_shift_ff <= tx_buf_ff & mask;
						tx_par_ff   <= (^(tx_buf_ff & mask)) ^ par_odd;
						tx_idx_ff   <= 4'd0;
						tx_stop2_ff <= 1'b0;
						tx_state_ff <= SDSR_START;
					end
				end
				SDSR_START: if (tx_bit_end) tx_state_ff <= SDSR_DATA;
				SDSR_DATA: begin
					if (tx_bit_end) begin
						tx_idx_ff <= tx_idx_ff + 4'd1;
						if (tx_idx_ff == nbits_m1) tx_state_ff <= par_en ? SDSR_PAR : SDSR_STOP;
					end
				end
				SDSR_PAR: if (tx_bit_end) tx_state_ff <= SDSR_STOP;
				SDSR_STOP: begin
					if (tx_done) tx_state_ff <= SDSR_IDLE;
					else if (tx_bit_end) tx_stop2_ff <= 1'b1;
				end
				default: tx_state_ff <= SDSR_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			txd_ff       <= 1'b1;
			drive_ff     <= 1'b0;
			rx_irq_ff    <= 1'b0;
			tx_irq_ff    <= 1'b0;
			empty_irq_ff <= 1'b0;
		end else begin
			case (tx_state_ff)
				SDSR_START: txd_ff <= 1'b0;
				SDSR_DATA:  txd_ff <= tx_shift_ff[tx_idx_ff];
				SDSR_PAR:   txd_ff <= tx_par_ff;
				default:    txd_ff <= 1'b1;
			endcase
			// Pin stays claimed until pending data has gone out
			drive_ff     <= txen | (tx_state_ff != SDSR_IDLE) | ~udre_ff;
			rx_irq_ff    <= rxc & ctrl_b_ff[SDSR_CB_RECEIVE_IRQ_ENABLE];
			tx_irq_ff    <= txc_ff & ctrl_b_ff[SDSR_CB_TRANSMIT_IRQ_ENABLE];
			empty_irq_ff <= udre_ff & ctrl_b_ff[SDSR_CB_EMPTY_IRQ_ENABLE];
		end
	end

	assign bus_readdata_out    = rdata_ff;
	assign bus_waitrequest_out = wait_ff;
	assign txd_out             = txd_ff;
	assign tx_drive_out        = drive_ff;
	assign rx_irq_out          = rx_irq_ff;
	assign tx_irq_out          = tx_irq_ff;
	assign empty_irq_out       = empty_irq_ff;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	property p_wr_full_dropped;
		wr_acc && hit_data && !udre_ff |=> $stable(tx_buf_ff) && !udre_ff;
	endproperty
	a_wr_full_dropped: assert property (p_wr_full_dropped) else $error("busy write landed");
	property p_load_shifter;
		tx_load |=> udre_ff && tx_state_ff == SDSR_START && tx_shift_ff == $past(tx_buf_ff & mask);
	endproperty
	a_load_shifter: assert property (p_load_shifter) else $error("shifter not loaded");
	property p_pop_count;
		pop && !move |=> fifo_cnt_ff == $past(fifo_cnt_ff) - 2'd1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("fifo did not advance");
	property p_rxc_read;
		bus_req_in.read && hit_stat && wait_ff |=> bus_readdata_out[7] == $past(rxc);
	endproperty
	a_rxc_read: assert property (p_rxc_read) else $error("rxc read wrong");
	property p_flush;
		!rxen |=> fifo_cnt_ff == 2'd0 && !hold_v_ff ##1 !rx_irq_out;
	endproperty
	a_flush: assert property (p_flush) else $error("flush failed");
	property p_txc_set;
		txc_set |=> txc_ff ##1 (tx_irq_out == ctrl_b_ff[SDSR_CB_TRANSMIT_IRQ_ENABLE] || !txc_ff);
	endproperty
	a_txc_set: assert property (p_txc_set) else $error("txc not set");
	property p_txc_clear;
		txc_clr && !txc_set |=> !txc_ff;
	endproperty
	a_txc_clear: assert property (p_txc_clear) else $error("txc not cleared");
	property p_reset_udre;
		$past(!resetn_in) |-> udre_ff && !txc_ff && bus_waitrequest_out;
	endproperty
	a_reset_udre: assert property (p_reset_udre) else $error("bad reset state");
	property p_spi_errs;
		bus_req_in.read && hit_stat && wait_ff && spi_mode |=> bus_readdata_out[4:2] == 3'b000;
	endproperty
	a_spi_errs: assert property (p_spi_errs) else $error("error bits in spi");
	property p_bit_period;
		tx_state_ff == SDSR_START && tx_bit_end |->
			int'(tx_clks_ff) == (int'(baud_ff) + 1) * (int'(tpb_m1) + 1) - 1;
	endproperty
	a_bit_period: assert property (p_bit_period) else $error("bit period wrong");
	property p_upper_zero;
		bus_req_in.read && hit_data && wait_ff && !nine && nbits_m1 < 4'd7
			|=> bus_readdata_out[7] == 1'b0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bit set");
	property p_wait_bound;
		req && wait_ff |=> !bus_waitrequest_out;
	endproperty
	a_wait_bound: assert property (p_wait_bound) else $error("no answer");

	c_fifo_full: cover property (fifo_cnt_ff == 2'd2 && hold_v_ff);
	c_overrun:   cover property (hold_ff.dor && move);
	c_txc:       cover property (txc_set);
	c_frame_err: cover property (keep && !rx_stop_ff);

endmodule : sdsr_core

// ==== tb/sdsr_remote.sv ====
// Remote serial transceiver: drives the receive line and captures the transmit line.
// Assumes one stop bit from the block and a bit period given in system clocks.
`timescale 1ns/1ps

module sdsr_remote (
	// Clock and timing
	input  wire logic clk_in,
	input  wire logic [31:0] bit_clks_in,
	// Serial lines
	input  wire logic txd_in,
	output logic      rxd_out
);
	logic [8:0] got_q[$];
	logic [8:0] cap;

	initial rxd_out = 1'b1;

	// Trailing idle bit so a zero stop bit still ends the frame cleanly
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		@(posedge clk_in);
		rxd_out <= 1'b0;
		repeat (bit_clks_in) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			rxd_out <= d[i];
			repeat (bit_clks_in) @(posedge clk_in);
		end
		rxd_out <= stop;
		repeat (bit_clks_in) @(posedge clk_in);
		rxd_out <= 1'b1;
		repeat (bit_clks_in) @(posedge clk_in);
	endtask : send

	// Mid-bit sampling of eight data bits and the stop bit
	always begin
		@(negedge txd_in);
		repeat (bit_clks_in / 2) @(posedge clk_in);
		for (int i = 0; i < 9; i++) begin
			repeat (bit_clks_in) @(posedge clk_in);
			cap[i] = txd_in;
		end
		got_q.push_back(cap);
	end
endmodule : sdsr_remote

// ==== tb/sdsr_core_tb_top.sv ====
// Self-checking bench: register accesses over Avalon-MM, serial traffic via the remote model.
// Assumes control_c resets to eight data bits, no parity, asynchronous mode.
`timescale 1ns/1ps

module sdsr_core_tb_top;
	import sdsr_pkg::*;
	logic          sys_clk_in;
	logic          resetn_in;
	logic          ack;
	logic          txd;
	logic          rxd;
	logic          drive;
	logic          irq_rx;
	logic          irq_tx;
	logic          irq_empty;
	logic          wait_r;
	logic [31:0]   rdata;
	logic [31:0]   q;
	sdsr_bus_req_s req;
	int            bad_count;
	int            tests_run;
	int            bit_clks;

	sdsr_core #(.DIV_W(12)) i_sdsr_core (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.bus_req_in(req), .bus_readdata_out(rdata), .bus_waitrequest_out(wait_r),
		.rxd_in(rxd), .txd_out(txd), .tx_drive_out(drive), .tx_irq_ack_in(ack),
		.rx_irq_out(irq_rx), .tx_irq_out(irq_tx), .empty_irq_out(irq_empty));
	sdsr_remote i_sdsr_remote (.clk_in(sys_clk_in), .bit_clks_in(bit_clks),
		.txd_in(txd), .rxd_out(rxd));

	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic print_verdict();
		$display("Checks run %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge sys_clk_in);
		req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk_in);
			if (wait_r === 1'b0) break;
		end
		if (n == 20) begin
			bad_count++;
			print_verdict();
		end
		q = rdata;
		req <= '0;
	endtask : acc

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		acc(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rd_chk

	task automatic wait_tx(input int n);
		int k;
		for (k = 0; k < 3000 && i_sdsr_remote.got_q.size() < n; k++) @(posedge sys_clk_in);
		if (k == 3000) begin
			bad_count++;
			print_verdict();
		end
	endtask : wait_tx

	initial begin
		resetn_in = 1'b0;
		req = '0;
		ack = 1'b0;
		bit_clks = 16;
		repeat (12) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rd_chk(SDSR_ADDR_STATUS_A, 32'h20);
		rd_chk(SDSR_ADDR_DATA, 32'h00);
		rd_chk(12'h004, 32'h00);
		acc(1'b1, SDSR_ADDR_CONTROL_B, 8'h18);
		acc(1'b1, SDSR_ADDR_DATA, 8'ha5);
		acc(1'b1, SDSR_ADDR_DATA, 8'h3c);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h00);
		acc(1'b1, SDSR_ADDR_DATA, 8'h77);
		wait_tx(2);
		chk(i_sdsr_remote.got_q[0], 32'h1a5);
		chk(i_sdsr_remote.got_q[1], 32'h13c);
		repeat (40) @(posedge sys_clk_in);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h60);
		acc(1'b1, SDSR_ADDR_STATUS_A, 8'h40);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h20);
		// FIFO full, third waiting, fourth start marks overrun
		i_sdsr_remote.send(9'h011, 8, 1'b1);
		i_sdsr_remote.send(9'h022, 8, 1'b0);
		i_sdsr_remote.send(9'h033, 8, 1'b1);
		i_sdsr_remote.send(9'h044, 8, 1'b1);
		rd_chk(SDSR_ADDR_STATUS_A, 32'ha0);
		rd_chk(SDSR_ADDR_DATA, 32'h11);
		rd_chk(SDSR_ADDR_STATUS_A, 32'hb0);
		acc(1'b1, SDSR_ADDR_CONTROL_C, 8'hc6);
		rd_chk(SDSR_ADDR_STATUS_A, 32'ha0);
		acc(1'b1, SDSR_ADDR_CONTROL_C, 8'h06);
		rd_chk(SDSR_ADDR_DATA, 32'h22);
		rd_chk(SDSR_ADDR_STATUS_A, 32'ha8);
		rd_chk(SDSR_ADDR_DATA, 32'h33);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h20);
		acc(1'b1, SDSR_ADDR_CONTROL_C, 8'h26);
		i_sdsr_remote.send(9'h001, 9, 1'b1);
		rd_chk(SDSR_ADDR_STATUS_A, 32'ha4);
		rd_chk(SDSR_ADDR_DATA, 32'h01);
		acc(1'b1, SDSR_ADDR_CONTROL_C, 8'h04);
		i_sdsr_remote.send(9'h0ff, 7, 1'b1);
		rd_chk(SDSR_ADDR_DATA, 32'h7f);
		acc(1'b1, SDSR_ADDR_CONTROL_C, 8'h06);
		i_sdsr_remote.send(9'h055, 8, 1'b1);
		acc(1'b1, SDSR_ADDR_CONTROL_B, 8'h08);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h20);
		acc(1'b1, SDSR_ADDR_CONTROL_B, 8'h18);
		acc(1'b1, SDSR_ADDR_BAUD, 8'h01);
		acc(1'b1, SDSR_ADDR_STATUS_A, 8'h02);
		acc(1'b1, SDSR_ADDR_DATA, 8'hc3);
		wait_tx(3);
		chk(i_sdsr_remote.got_q[2], 32'h1c3);
		acc(1'b1, SDSR_ADDR_STATUS_A, 8'h03);
		i_sdsr_remote.send(9'h099, 8, 1'b1);
		rd_chk(SDSR_ADDR_STATUS_A, 32'h63);
		acc(1'b1, SDSR_ADDR_CONTROL_B, 8'hf8);
		acc(1'b1, SDSR_ADDR_STATUS_A, 8'h02);
		i_sdsr_remote.send(9'h05a, 8, 1'b1);
		repeat (2) @(posedge sys_clk_in);
		chk({drive, irq_rx, irq_tx, irq_empty}, 32'hf);
		ack <= 1'b1;
		@(posedge sys_clk_in);
		ack <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		chk({drive, irq_rx, irq_tx, irq_empty}, 32'hd);
		rd_chk(SDSR_ADDR_STATUS_A, 32'ha2);
		print_verdict();
	end
endmodule : sdsr_core_tb_top
